/* File: design/swc_map.svh */
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define SWC_OFF_CTRL        8'h00
`define SWC_OFF_STATUS      8'h04
`define SWC_OFF_FLAG_CLR    8'h08
`define SWC_OFF_EVT_STATUS  8'h0C
`define SWC_OFF_EVT_CLEAR   8'h10
`define SWC_OFF_EVT_ENABLE  8'h14

////////////////////////////////////////////////////////////////////////
// control fields
`define SWC_CTRL_W          6
`define SWC_CTRL_WDT_EN     0
`define SWC_CTRL_GIE        1
`define SWC_CTRL_EXT_EN     2
`define SWC_CTRL_PCH_EN     3
`define SWC_CTRL_CMP_EN     4
`define SWC_CTRL_EXT_POL    5
`define SWC_CTRL_RST        6'h01

////////////////////////////////////////////////////////////////////////
// status fields
`define SWC_STAT_TO         0
`define SWC_STAT_PD         1
`define SWC_STAT_ASLEEP     2
`define SWC_STAT_EXT_FLAG   3
`define SWC_STAT_PCH_FLAG   4
`define SWC_STAT_CMP_FLAG   5
`define SWC_FLAG_CLR_EXT    0

////////////////////////////////////////////////////////////////////////
// event fields
`define SWC_EVT_W           4
`define SWC_EVT_WAKE        0
`define SWC_EVT_WDT_RST     1
`define SWC_EVT_SLEEP_NOP   2
`define SWC_EVT_SLEEP_IN    3
`define SWC_EVT_RST         4'h0

////////////////////////////////////////////////////////////////////////
// vector and timing
`define SWC_IRQ_VECTOR      16'h0004
`define SWC_CLK_PERIOD_NS   5
`define SWC_WDT_PERIOD_MS   18
`define SWC_WDT_CYCLES      ((`SWC_WDT_PERIOD_MS * 1000000) / `SWC_CLK_PERIOD_NS)

`endif

/* File: design/swc_pkg.sv */
package swc_pkg;

  typedef enum logic {
    swc_run,
    swc_asleep
  } swc_state_t;

  typedef logic [31:0] swc_word_t;

endpackage

/* File: design/swc_wdt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface swc_wdt_if;
  logic clear;
  logic enable;
  logic timeout;

  modport ctrl (output clear, output enable, input timeout);
  modport wdt (input clear, input enable, output timeout);
endinterface
`default_nettype wire

/* File: design/swc_watchdog.sv */
`timescale 1ns/10ps
`default_nettype none
module swc_watchdog #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  swc_wdt_if.wdt    bus
);

  localparam int unsigned CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  if (CYCLES < 2) begin : g_chk
    $error("watchdog period must be at least two cycles");
  end

  logic [CW-1:0] cnt_reg;
  logic          timeout_reg;

  ////////////////////////////////////////////////////////////////////////
  // counter, cleared but kept running
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear || !bus.enable || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= bus.enable && !bus.clear && cnt_reg == LAST;
    end
  end

  assign bus.timeout = timeout_reg;

endmodule // swc_watchdog
`default_nettype wire

/* File: design/swc_top.sv */
// Behaviour
// - executed sleep clears watchdog, clears power-down flag, sets time-out flag, stops oscillator
// - pad drive and enable hold their pre-sleep values while asleep
// - wake on device reset, enabled watchdog time-out, or enabled interrupt source
// - reset wake resets the core; watchdog or interrupt wake resumes without reset
// - power-down flag set at power-up, cleared by sleep; time-out cleared by watchdog wake
// - sleep prefetches the instruction at the following address
// - interrupt wakes only with its own enable, independent of global enable
// - after wake, global enable clear continues in-line; set runs next then vectors
// - sleep with an enabled pending interrupt acts as no-operation: watchdog, flags and state unchanged, sleep-nop event set
// - interrupt during or after sleep lets sleep complete, then wakes at once
// - watchdog time-out wakes when asleep, resets the core when running
// - taking an interrupt clears global enable, pushes return address, jumps to vector
// - edge pin wakes only if its enable was set before sleep
`timescale 1ns/10ps
`default_nettype none
`include "swc_map.svh"
module swc_top #(
  parameter int unsigned PC_W       = 13,
  parameter int unsigned PAD_W      = 8,
  parameter int unsigned WDT_CYCLES = `SWC_WDT_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  input  wire logic             sleep_instr_i,
  input  wire logic             watchdog_clear_instr_i,
  input  wire logic             retire_i,
  input  wire logic             gie_set_i,
  input  wire logic [PC_W-1:0]  pc_i,
  input  wire logic             port_change_flag_i,
  input  wire logic             comparator_flag_i,
  input  wire logic             ext_edge_irq_pin_i,
  input  wire logic             dev_reset_n_i,
  input  wire logic [PAD_W-1:0] port_out_i,
  input  wire logic [PAD_W-1:0] port_oe_i,
  output logic      [PAD_W-1:0] pad_out_o,
  output logic      [PAD_W-1:0] pad_oe_o,
  output logic                  osc_en_o,
  output logic                  asleep_o,
  output logic                  core_reset_o,
  output logic                  resume_o,
  output logic                  prefetch_o,
  output logic      [PC_W-1:0]  prefetch_addr_o,
  output logic                  push_o,
  output logic      [PC_W-1:0]  push_addr_o,
  output logic                  branch_o,
  output logic      [PC_W-1:0]  branch_addr_o
);

  if (PC_W < 3 || PC_W > 16) begin : g_chk_pc
    $error("program counter width must be 3 to 16");
  end
  if (PAD_W < 1) begin : g_chk_pad
    $error("pad width must be at least one");
  end

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations
  swc_pkg::swc_state_t    state_reg;
  swc_pkg::swc_state_t    state_next;
  logic [`SWC_CTRL_W-1:0] ctrl_reg;
  logic                   pd_flag_reg;
  logic                   to_flag_reg;
  logic                   ext_flag_reg;
  logic                   ext_en_sleep_reg;
  logic [`SWC_EVT_W-1:0]  evt_reg;
  logic [`SWC_EVT_W-1:0]  evt_en_reg;
  logic [`SWC_EVT_W-1:0]  evt_set;
  logic                   ext_s1_reg;
  logic                   ext_s2_reg;
  logic                   ext_s3_reg;
  logic                   ext_lvl_reg;
  logic                   rstp_s1_reg;
  logic                   rstp_s2_reg;
  logic                   rstp_s3_reg;
  logic                   rstp_lvl_reg;
  logic                   ack_reg;
  logic [31:0]            dat_reg;
  logic [31:0]            rdata;
  logic                   irq_reg;
  logic [PAD_W-1:0]       pad_out_reg;
  logic [PAD_W-1:0]       pad_oe_reg;
  logic                   osc_en_reg;
  logic                   asleep_reg;
  logic                   core_reset_reg;
  logic                   resume_reg;
  logic                   prefetch_reg;
  logic [PC_W-1:0]        prefetch_addr_reg;
  logic                   push_reg;
  logic [PC_W-1:0]        push_addr_reg;
  logic                   branch_reg;
  logic                   bus_req;
  logic                   bus_wr;
  logic                   ext_edge;
  logic                   rstp_fall;
  logic                   rstp_held;
  logic                   pend_run;
  logic                   pend_wake;
  logic                   sleep_exec;
  logic                   sleep_nop;
  logic                   wake_irq;
  logic                   wake_wdt;
  logic                   wdt_rst;
  logic                   take_irq;
  logic                   running;
  logic                   asleep;

  swc_wdt_if wdt_bus ();

  swc_watchdog #(
    .CYCLES (WDT_CYCLES)
  ) u_watchdog (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (wdt_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_edge_irq_pin_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) begin
        ext_lvl_reg <= ext_s3_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstp_s1_reg  <= 1'b1;
      rstp_s2_reg  <= 1'b1;
      rstp_s3_reg  <= 1'b1;
      rstp_lvl_reg <= 1'b1;
    end else begin
      rstp_s1_reg <= dev_reset_n_i;
      rstp_s2_reg <= rstp_s1_reg;
      rstp_s3_reg <= rstp_s2_reg;
      if (rstp_s2_reg == rstp_s3_reg) begin
        rstp_lvl_reg <= rstp_s3_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake and sleep decisions
  always_comb begin
    running   = (state_reg == swc_pkg::swc_run);
    asleep    = (state_reg == swc_pkg::swc_asleep);
    ext_edge  = (ext_s2_reg == ext_s3_reg) && (ext_s3_reg != ext_lvl_reg) &&
                (ext_s3_reg == ctrl_reg[`SWC_CTRL_EXT_POL]);
    rstp_fall = (rstp_s2_reg == rstp_s3_reg) && !rstp_s3_reg && rstp_lvl_reg;
    rstp_held = !rstp_lvl_reg;
    pend_run  = (ext_flag_reg && ctrl_reg[`SWC_CTRL_EXT_EN]) ||
                (port_change_flag_i && ctrl_reg[`SWC_CTRL_PCH_EN]) ||
                (comparator_flag_i && ctrl_reg[`SWC_CTRL_CMP_EN]);
    pend_wake = (ext_flag_reg && ctrl_reg[`SWC_CTRL_EXT_EN] && ext_en_sleep_reg) ||
                (port_change_flag_i && ctrl_reg[`SWC_CTRL_PCH_EN]) ||
                (comparator_flag_i && ctrl_reg[`SWC_CTRL_CMP_EN]);
    sleep_nop  = running && sleep_instr_i && !rstp_held && pend_run;
    sleep_exec = running && sleep_instr_i && !rstp_held && !pend_run;
    wake_irq   = asleep && pend_wake;
    wake_wdt   = asleep && wdt_bus.timeout;
    wdt_rst    = running && wdt_bus.timeout;
    take_irq   = running && retire_i && !sleep_instr_i && !rstp_held &&
                 ctrl_reg[`SWC_CTRL_GIE] && pend_run;
  end

  assign wdt_bus.clear  = sleep_exec || watchdog_clear_instr_i || rstp_held;
  assign wdt_bus.enable = ctrl_reg[`SWC_CTRL_WDT_EN];

  always_comb begin
    state_next = state_reg;
    if (rstp_held || rstp_fall) begin
      state_next = swc_pkg::swc_run;
    end else begin
      unique case (state_reg)
        swc_pkg::swc_run: begin
          if (sleep_exec) begin
            state_next = swc_pkg::swc_asleep;
          end
        end
        swc_pkg::swc_asleep: begin
          if (wake_irq || wake_wdt) begin
            state_next = swc_pkg::swc_run;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= swc_pkg::swc_run;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_flag_reg <= 1'b1;
    end else if (sleep_exec) begin
      pd_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_flag_reg <= 1'b1;
    end else if (wake_wdt || wdt_rst) begin
      to_flag_reg <= 1'b0;
    end else if (sleep_exec) begin
      to_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_flag_reg <= 1'b0;
    end else if (ext_edge) begin
      ext_flag_reg <= 1'b1;
    end else if (bus_wr && reg_hit(wb_adr_i, `SWC_OFF_FLAG_CLR) && wb_sel_i[0] &&
                 wb_dat_i[`SWC_FLAG_CLR_EXT]) begin
      ext_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_en_sleep_reg <= 1'b0;
    end else if (sleep_exec) begin
      ext_en_sleep_reg <= ctrl_reg[`SWC_CTRL_EXT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and global enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SWC_CTRL_RST;
    end else begin
      if (bus_wr && reg_hit(wb_adr_i, `SWC_OFF_CTRL) && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[`SWC_CTRL_W-1:0];
      end
      if (take_irq) begin
        ctrl_reg[`SWC_CTRL_GIE] <= 1'b0;
      end else if (gie_set_i) begin
        ctrl_reg[`SWC_CTRL_GIE] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events and interrupt
  assign evt_set = {sleep_exec, sleep_nop, wdt_rst, wake_irq || wake_wdt || (asleep && rstp_fall)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_reg <= `SWC_EVT_RST;
    end else if (bus_wr && reg_hit(wb_adr_i, `SWC_OFF_EVT_CLEAR) && wb_sel_i[0]) begin
      evt_reg <= (evt_reg & ~wb_dat_i[`SWC_EVT_W-1:0]) | evt_set;
    end else begin
      evt_reg <= evt_reg | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_en_reg <= `SWC_EVT_RST;
    end else if (bus_wr && reg_hit(wb_adr_i, `SWC_OFF_EVT_ENABLE) && wb_sel_i[0]) begin
      evt_en_reg <= wb_dat_i[`SWC_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_reg & evt_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  // write lands at the edge where the master samples ack high
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

  always_comb begin
    rdata = 32'h0000_0000;
    if (reg_hit(wb_adr_i, `SWC_OFF_CTRL)) begin
      rdata[`SWC_CTRL_W-1:0] = ctrl_reg;
    end else if (reg_hit(wb_adr_i, `SWC_OFF_STATUS)) begin
      rdata[`SWC_STAT_TO]       = to_flag_reg;
      rdata[`SWC_STAT_PD]       = pd_flag_reg;
      rdata[`SWC_STAT_ASLEEP]   = asleep;
      rdata[`SWC_STAT_EXT_FLAG] = ext_flag_reg;
      rdata[`SWC_STAT_PCH_FLAG] = port_change_flag_i;
      rdata[`SWC_STAT_CMP_FLAG] = comparator_flag_i;
    end else if (reg_hit(wb_adr_i, `SWC_OFF_EVT_STATUS)) begin
      rdata[`SWC_EVT_W-1:0] = evt_reg;
    end else if (reg_hit(wb_adr_i, `SWC_OFF_EVT_ENABLE)) begin
      rdata[`SWC_EVT_W-1:0] = evt_en_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_reg <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad hold and oscillator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_reg <= '0;
      pad_oe_reg  <= '0;
    end else if (running && !sleep_exec) begin
      pad_out_reg <= port_out_i;
      pad_oe_reg  <= port_oe_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_reg <= 1'b1;
      asleep_reg <= 1'b0;
    end else begin
      osc_en_reg <= (state_next == swc_pkg::swc_run);
      asleep_reg <= (state_next == swc_pkg::swc_asleep);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core sequencing strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_reg <= 1'b0;
      resume_reg     <= 1'b0;
    end else begin
      core_reset_reg <= rstp_held || rstp_fall || wdt_rst;
      resume_reg     <= (wake_irq || wake_wdt) && !rstp_fall && !rstp_held;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefetch_reg      <= 1'b0;
      prefetch_addr_reg <= '0;
    end else begin
      prefetch_reg <= sleep_exec || sleep_nop;
      if (sleep_exec || sleep_nop) begin
        prefetch_addr_reg <= pc_i + PC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_reg      <= 1'b0;
      push_addr_reg <= '0;
      branch_reg    <= 1'b0;
    end else begin
      push_reg   <= take_irq;
      branch_reg <= take_irq;
      if (take_irq) begin
        push_addr_reg <= pc_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_o        = dat_reg;
  assign wb_ack_o        = ack_reg;
  assign irq_o           = irq_reg;
  assign pad_out_o       = pad_out_reg;
  assign pad_oe_o        = pad_oe_reg;
  assign osc_en_o        = osc_en_reg;
  assign asleep_o        = asleep_reg;
  assign core_reset_o    = core_reset_reg;
  assign resume_o        = resume_reg;
  assign prefetch_o      = prefetch_reg;
  assign prefetch_addr_o = prefetch_addr_reg;
  assign push_o          = push_reg;
  assign push_addr_o     = push_addr_reg;
  assign branch_o        = branch_reg;
  assign branch_addr_o   = PC_W'(`SWC_IRQ_VECTOR);

endmodule // swc_top
`default_nettype wire

/* File: dv/swc_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "swc_map.svh"
module swc_sva #(
  parameter int unsigned PC_W  = 13,
  parameter int unsigned PAD_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             sleep_instr_i,
  input wire logic             retire_i,
  input wire logic [PC_W-1:0]  pc_i,
  input wire logic             dev_reset_n_i,
  input wire logic [PAD_W-1:0] pad_out_o,
  input wire logic [PAD_W-1:0] pad_oe_o,
  input wire logic             osc_en_o,
  input wire logic             asleep_o,
  input wire logic             core_reset_o,
  input wire logic             resume_o,
  input wire logic             prefetch_o,
  input wire logic [PC_W-1:0]  prefetch_addr_o,
  input wire logic             push_o,
  input wire logic [PC_W-1:0]  push_addr_o,
  input wire logic             branch_o,
  input wire logic [PC_W-1:0]  branch_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  osc_asleep_a: assert property (asleep_o == !osc_en_o)
    else $error("asleep and oscillator disagree");
  enter_sleep_a: assert property ($rose(asleep_o) |-> $past(sleep_instr_i) && prefetch_o)
    else $error("sleep entry without instruction or prefetch");
  prefetch_addr_a: assert property (prefetch_o |-> $past(sleep_instr_i) &&
    prefetch_addr_o == PC_W'($past(pc_i) + 1'b1)) else $error("prefetch address wrong");
  pads_frozen_a: assert property (asleep_o && $past(asleep_o) |->
    $stable(pad_out_o) && $stable(pad_oe_o)) else $error("pads moved while asleep");
  resume_wake_a: assert property (resume_o |-> $past(asleep_o) && !asleep_o && !core_reset_o)
    else $error("resume without wake from sleep");
  osc_wake_a: assert property ($rose(osc_en_o) |-> resume_o || core_reset_o || $past(core_reset_o))
    else $error("oscillator restarted without wake cause");
  push_addr_a: assert property (push_o |-> branch_o && $past(retire_i) &&
    push_addr_o == $past(pc_i)) else $error("push without retire or wrong address");
  vector_addr_a: assert property (branch_o |-> !$past(asleep_o) &&
    branch_addr_o == PC_W'(`SWC_IRQ_VECTOR)) else $error("branch target wrong");
  reset_pin_a: assert property ($fell(dev_reset_n_i) |-> ##[1:8] core_reset_o)
    else $error("reset pin gave no core reset");
endmodule  // swc_sva

bind swc_top swc_sva #(.PC_W(PC_W), .PAD_W(PAD_W)) u_swc_sva (
  .clk_i, .rst_i, .sleep_instr_i, .retire_i, .pc_i, .dev_reset_n_i, .pad_out_o, .pad_oe_o,
  .osc_en_o, .asleep_o, .core_reset_o, .resume_o, .prefetch_o, .prefetch_addr_o, .push_o,
  .push_addr_o, .branch_o, .branch_addr_o);
`default_nettype wire

/* File: dv/swc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module swc_core_model #(
  parameter int unsigned PC_W = 13
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            slow_i,
  input  wire logic            osc_en_i,
  input  wire logic            core_reset_i,
  input  wire logic            branch_i,
  input  wire logic [PC_W-1:0] branch_addr_i,
  output logic                 retire_o,
  output logic      [PC_W-1:0] pc_o
);
  logic phase_reg;

  ////////////////////////////////////////////////////////////////////////
  // instruction stream, one retire every other cycle when slow
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_i) begin
      phase_reg <= 1'b0;
      retire_o  <= 1'b0;
      pc_o      <= '0;
    end else begin
      phase_reg <= !phase_reg;
      retire_o  <= osc_en_i && (!slow_i || phase_reg);
      if (branch_i) begin
        pc_o <= branch_addr_i;
      end else if (retire_o) begin
        pc_o <= pc_o + 1'b1;
      end
    end
  end
endmodule  // swc_core_model
`default_nettype wire

/* File: dv/sleep_wakeup_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "swc_map.svh"
module sleep_wakeup_control_bench;
  localparam int PC_W = 13;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, sleep_instr_i, retire_i;
  logic        watchdog_clear_instr_i, gie_set_i, port_change_flag_i, comparator_flag_i, slow;
  logic        ext_edge_irq_pin_i, dev_reset_n_i, osc_en_o, asleep_o, core_reset_o, resume_o;
  logic        prefetch_o, push_o, branch_o, r, c;
  logic [7:0]  wb_adr_i, port_out_i, port_oe_i, pad_out_o, pad_oe_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [PC_W-1:0] pc_i, prefetch_addr_o, push_addr_o, branch_addr_o, p;
  int          num_errors, samples_checked, pushes, n;

  swc_top #(.WDT_CYCLES(40)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .sleep_instr_i, .watchdog_clear_instr_i,
    .retire_i, .gie_set_i, .pc_i, .port_change_flag_i, .comparator_flag_i, .ext_edge_irq_pin_i,
    .dev_reset_n_i, .port_out_i, .port_oe_i, .pad_out_o, .pad_oe_o, .osc_en_o, .asleep_o,
    .core_reset_o, .resume_o, .prefetch_o, .prefetch_addr_o, .push_o, .push_addr_o, .branch_o,
    .branch_addr_o);
  swc_core_model #(.PC_W(PC_W)) u_core (.clk_i, .rst_i, .slow_i(slow), .osc_en_i(osc_en_o),
    .core_reset_i(core_reset_o), .branch_i(branch_o), .branch_addr_i(branch_addr_o),
    .retire_o(retire_i), .pc_o(pc_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = !clk_i;
  end
  always @(posedge clk_i) if (push_o === 1'b1) pushes++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin @(posedge clk_i); end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, '0);
    chk(q, exp);
  endtask
  task automatic sleep_go;
    @(posedge clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    p = pc_i;
    sleep_instr_i <= 1'b0;
  endtask
  task automatic wake_wait(input int lim);
    int k = 0;
    do begin @(posedge clk_i); k++; end while (resume_o !== 1'b1 && core_reset_o !== 1'b1 && k < lim);
    {r, c} = {resume_o, core_reset_o};
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_wdt;
    rdc(`SWC_OFF_STATUS, 32'h3);
    rdc(8'h1C, 32'h0);
    wake_wait(60);
    chk({r, c}, 2'b01);
    wb(1'b1, `SWC_OFF_CTRL, 32'h10);
    rdc(`SWC_OFF_STATUS, 32'h2);
    wb(1'b1, `SWC_OFF_EVT_CLEAR, 32'hF);
  endtask
  task automatic t_noop;
    comparator_flag_i <= 1'b1;
    sleep_go();
    @(posedge clk_i);
    chk({asleep_o, prefetch_o}, 2'b01);
    chk(prefetch_addr_o, PC_W'(p + 1'b1));
    rdc(`SWC_OFF_STATUS, 32'h22);
    comparator_flag_i <= 1'b0;
  endtask
  task automatic t_sleep_cmp;
    wb(1'b1, `SWC_OFF_EVT_ENABLE, 32'h8);
    {port_out_i, port_oe_i} <= 16'hA50F;
    sleep_go();
    @(posedge clk_i);
    chk({asleep_o, osc_en_o, prefetch_o}, 3'b101);
    chk(prefetch_addr_o, PC_W'(p + 1'b1));
    {port_out_i, port_oe_i} <= 16'h5AF0;
    rdc(`SWC_OFF_STATUS, 32'h5);
    chk({pad_out_o, pad_oe_o}, 16'hA50F);
    chk(irq_o, 1'b1);
    wb(1'b1, `SWC_OFF_EVT_CLEAR, 32'h8);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    n = pushes;
    comparator_flag_i <= 1'b1;
    wake_wait(10);
    chk({r, c, osc_en_o}, 3'b101);
    repeat (8) @(posedge clk_i);
    chk(pushes, n);
    rdc(`SWC_OFF_EVT_STATUS, 32'h5);
    chk(irq_o, 1'b0);
    comparator_flag_i <= 1'b0;
  endtask
  task automatic t_sleep_gie;
    int k = 0;
    wb(1'b1, `SWC_OFF_CTRL, 32'h12);
    slow <= 1'b1;
    sleep_go();
    comparator_flag_i <= 1'b1;
    @(posedge clk_i);
    chk(asleep_o, 1'b1);
    wake_wait(3);
    chk({r, c}, 2'b10);
    while (push_o !== 1'b1 && k < 12) begin @(posedge clk_i); k++; end
    chk({push_o, branch_o, branch_addr_o}, {2'b11, PC_W'(`SWC_IRQ_VECTOR)});
    comparator_flag_i <= 1'b0;
    rdc(`SWC_OFF_CTRL, 32'h10);
    slow <= 1'b0;
  endtask
  task automatic t_wdt_wake;
    wb(1'b1, `SWC_OFF_CTRL, 32'h01);
    sleep_go();
    wake_wait(60);
    chk({r, c}, 2'b10);
    wb(1'b1, `SWC_OFF_CTRL, 32'h00);
    rdc(`SWC_OFF_STATUS, 32'h0);
  endtask
  task automatic t_reset_pin;
    sleep_go();
    dev_reset_n_i <= 1'b0;
    wake_wait(12);
    chk({r, c}, 2'b01);
    repeat (3) @(posedge clk_i);
    dev_reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({core_reset_o, asleep_o}, 2'b00);
  endtask
  task automatic t_ext_wake;
    wb(1'b1, `SWC_OFF_CTRL, 32'h24);
    sleep_go();
    ext_edge_irq_pin_i <= 1'b1;
    wake_wait(12);
    chk({r, c}, 2'b10);
    rdc(`SWC_OFF_STATUS, 32'h9);
    wb(1'b1, `SWC_OFF_FLAG_CLR, 32'h1);
    rdc(`SWC_OFF_STATUS, 32'h1);
    wb(1'b1, `SWC_OFF_CTRL, 32'h00);
  endtask

  initial begin
    {rst_i, dev_reset_n_i, wb_sel_i} = {2'b11, 4'hF};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, sleep_instr_i, slow} = '0;
    {watchdog_clear_instr_i, gie_set_i, port_change_flag_i, comparator_flag_i} = '0;
    {ext_edge_irq_pin_i, port_out_i, port_oe_i, num_errors, samples_checked, pushes} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_wdt();
    t_noop();
    t_sleep_cmp();
    t_sleep_gie();
    t_wdt_wake();
    t_reset_pin();
    t_ext_wake();
    wrap_up();
  end
  initial begin
    #20us;
    num_errors++;
    wrap_up();
  end
endmodule  // sleep_wakeup_control_bench
`default_nettype wire
